// [lrs_regs.svh]
// constants for the two-wire regulator control port
`ifndef LRS_REGS_SVH
`define LRS_REGS_SVH
`define LRS_ADDR_FIXED   5'h02
`define LRS_REG_INDEX    8'h00
`define LRS_CTRL_RESET   8'h00
`define LRS_CLK_DIV      16'h0008
`endif

// [lrs_pkg.sv]
// shared types for the two-wire regulator control port
`default_nettype none
package lrs_pkg;
  typedef enum logic [2:0]
  {
    LRS_IDLE  = 3'b000,
    LRS_ADDR  = 3'b001,
    LRS_INDEX = 3'b010,
    LRS_WDATA = 3'b011,
    LRS_RDATA = 3'b100,
    LRS_SKIP  = 3'b101
  } lrs_state_t;
  typedef enum logic [1:0]
  {
    LRS_OP_WRITE = 2'b00,
    LRS_OP_INDEX = 2'b01,
    LRS_OP_READ  = 2'b10
  } lrs_op_t;
endpackage
`default_nettype wire

// [lrs_bus_if.sv]
// two-wire bus joining the regulator port and its master
`timescale 1ns/100ps
`default_nettype none
interface lrs_bus_if;
  logic scl_in;
  logic sda_in;
  logic dev_sda_oe_n;
  logic mst_scl_oe_n;
  logic mst_sda_oe_n;
  // wired-and of the open-drain drivers with pull-ups
  assign scl_in = mst_scl_oe_n;
  assign sda_in = dev_sda_oe_n & mst_sda_oe_n;
  modport device (input scl_in, input sda_in, output dev_sda_oe_n);
  modport master (input scl_in, input sda_in, output mst_scl_oe_n, output mst_sda_oe_n);
endinterface
`default_nettype wire

// [lrs_sync.sv]
// two-stage synchroniser with edge and start/stop detection
`timescale 1ns/100ps
`default_nettype none
module lrs_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  output logic      scl,
  output logic      sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_seen,
  output logic      stop_seen
);
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic       scl_prev;
  logic       sda_prev;
  // two flops per line, then one history flop
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      scl_meta <= 2'b11;
      sda_meta <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= {scl_meta[0], scl_pin};
      sda_meta <= {sda_meta[0], sda_pin};
      scl_prev <= scl_meta[1];
      sda_prev <= sda_meta[1];
    end
  assign scl        = scl_meta[1];
  assign sda        = sda_meta[1];
  assign scl_rise   = scl & ~scl_prev;
  assign scl_fall   = ~scl & scl_prev;
  assign start_seen = scl & scl_prev & sda_prev & ~sda;
  assign stop_seen  = scl & scl_prev & ~sda_prev & sda;
endmodule
`default_nettype wire

// [lrs_device.sv]
// regulator end of the two-wire port: control write and status read
// Summary of operation
// - slave giving access to control, status only
// - master clocks; both lines open drain
// - lines released high when idle
// - data changes only while clock low
// - ack low after eight good bits
// - master acks the eight status bits
// - missing bits answered with high nack
// - ack address only on valid match
// - write gives three device acknowledges
// - read gives four acknowledges in total
// - register index byte is all zeros
// - start or stop abandons the sequence
// - fault flags clear after master ack
`timescale 1ns/100ps
`include "lrs_regs.svh"
`default_nettype none
module lrs_device
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  lrs_bus_if.device       bus,
  input  wire logic [1:0] addr_strap,
  input  wire logic [7:0] status_live,
  input  wire logic [7:0] fault_set,
  output logic      [7:0] ctrl_reg,
  output logic            ctrl_wr_pulse,
  output logic      [7:0] fault_latched
);
  logic             scl;
  logic             sda;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_seen;
  logic             stop_seen;
  lrs_pkg::lrs_state_t state;
  lrs_pkg::lrs_state_t next_state;
  logic       [3:0] bit_cnt;
  logic       [7:0] shift;
  logic       [7:0] tx_byte;
  logic             ack_phase;
  logic             sda_oe_n;
  logic             stat_sent;
  logic       [1:0] strap_meta;
  logic       [1:0] strap;
  logic       [7:0] shift_next;
  logic       [6:0] own_addr;
  logic             addr_match;
  logic             byte_done;
  logic             idx_good;
  logic             master_ack;
  logic             drive_data;
  logic             clear_faults;

  // lines enter through the synchroniser
  lrs_sync i_lrs_sync
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .scl_pin    (bus.scl_in),
    .sda_pin    (bus.sda_in),
    .scl        (scl),
    .sda        (sda),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap pin caught through two flops
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      strap_meta <= 2'b00;
      strap      <= 2'b00;
    end
    else
    begin
      strap_meta <= addr_strap;
      strap      <= strap_meta;
    end

  // decode of the received byte
  assign shift_next = {shift[6:0], sda};
  assign own_addr   = {`LRS_ADDR_FIXED, strap};
  assign addr_match = shift[7:1] == own_addr;
  assign byte_done  = bit_cnt == 4'h8;
  assign idx_good   = shift == `LRS_REG_INDEX;
  assign master_ack   = ack_phase & scl_rise & ~sda;
  assign drive_data   = (state == lrs_pkg::LRS_RDATA) & ~ack_phase;
  assign clear_faults = master_ack & stat_sent;

  ////////////////////////////////////////////////////////////////////////////
  // sequence control on each byte boundary
  always_comb
  begin
    next_state = state;
    if (byte_done && scl_fall && !ack_phase)
      case (state)
        lrs_pkg::LRS_ADDR:
          if (!addr_match)
            next_state = lrs_pkg::LRS_SKIP;
          else if (shift[0])
            next_state = lrs_pkg::LRS_RDATA;
          else
            next_state = lrs_pkg::LRS_INDEX;
        lrs_pkg::LRS_INDEX:
          next_state = idx_good ? lrs_pkg::LRS_WDATA : lrs_pkg::LRS_SKIP;
        lrs_pkg::LRS_WDATA:
          next_state = lrs_pkg::LRS_SKIP;
        lrs_pkg::LRS_RDATA:
          next_state = lrs_pkg::LRS_SKIP;
        default:
          next_state = state;
      endcase
  end

  // state and bit counters; start or stop restarts
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      state     <= lrs_pkg::LRS_IDLE;
      bit_cnt   <= 4'h0;
      ack_phase <= 1'b0;
    end
    else if (start_seen)
    begin
      state     <= lrs_pkg::LRS_ADDR;
      bit_cnt   <= 4'h0;
      ack_phase <= 1'b0;
    end
    else if (stop_seen)
    begin
      state     <= lrs_pkg::LRS_IDLE;
      bit_cnt   <= 4'h0;
      ack_phase <= 1'b0;
    end
    else if (scl_fall)
    begin
      if (ack_phase)
      begin
        ack_phase <= 1'b0;
        bit_cnt   <= 4'h0;
      end
      else if (byte_done)
      begin
        state     <= next_state;
        ack_phase <= (next_state != lrs_pkg::LRS_SKIP) || (state == lrs_pkg::LRS_WDATA)
                     || (state == lrs_pkg::LRS_INDEX && !idx_good) || (state == lrs_pkg::LRS_RDATA);
        bit_cnt   <= 4'h0;
      end
    end
    else if (scl_rise && !ack_phase && !byte_done)
      bit_cnt <= bit_cnt + 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // receive shifter, sampled while clock high
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      shift <= 8'h00;
    else if (scl_rise && !ack_phase)
      shift <= shift_next;

  // status byte sent, master acknowledge slot pending
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      stat_sent <= 1'b0;
    else if (start_seen || stop_seen)
      stat_sent <= 1'b0;
    else if (scl_fall)
      stat_sent <= (state == lrs_pkg::LRS_RDATA) && byte_done && !ack_phase;

  // transmit byte loaded at read address, shifted on falls
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      tx_byte <= 8'h00;
    else if (next_state == lrs_pkg::LRS_RDATA && state == lrs_pkg::LRS_ADDR && byte_done && scl_fall)
      tx_byte <= status_live | fault_latched;
    else if (drive_data && scl_fall && !ack_phase)
      tx_byte <= {tx_byte[6:0], 1'b1};

  // data driver changes on clock fall, and is released at once on start or stop
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      sda_oe_n <= 1'b1;
    else if (start_seen || stop_seen)
      sda_oe_n <= 1'b1;
    else if (scl_fall)
    begin
      if (byte_done && !ack_phase && state != lrs_pkg::LRS_SKIP && state != lrs_pkg::LRS_IDLE
          && state != lrs_pkg::LRS_RDATA && (state != lrs_pkg::LRS_ADDR || addr_match)
          && (state != lrs_pkg::LRS_INDEX || idx_good))
        sda_oe_n <= 1'b0;
      else if (byte_done && !ack_phase && state == lrs_pkg::LRS_ADDR && addr_match && shift[0])
        sda_oe_n <= 1'b0;
      else if (ack_phase && state == lrs_pkg::LRS_RDATA)
        sda_oe_n <= tx_byte[7];                                  // msb first
      else if (drive_data && !byte_done)
        sda_oe_n <= tx_byte[6];
      else
        sda_oe_n <= 1'b1;
    end

  ////////////////////////////////////////////////////////////////////////////
  // control register write and fault latches
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_reg      <= `LRS_CTRL_RESET;
      ctrl_wr_pulse <= 1'b0;
    end
    else
    begin
      ctrl_wr_pulse <= 1'b0;
      if (state == lrs_pkg::LRS_WDATA && byte_done && scl_fall && !ack_phase)
      begin
        ctrl_reg      <= shift;
        ctrl_wr_pulse <= 1'b1;
      end
    end

  // latched faults; a new fault wins over the clear
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      fault_latched <= 8'h00;
    else
      fault_latched <= (clear_faults ? 8'h00 : fault_latched) | fault_set;

  assign bus.dev_sda_oe_n = sda_oe_n;
endmodule
`default_nettype wire

// [lrs_master.sv]
// host end of the two-wire port: issues control writes and status reads
`timescale 1ns/100ps
`include "lrs_regs.svh"
`default_nettype none
module lrs_master
#(
  parameter int CLK_DIV = `LRS_CLK_DIV
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  lrs_bus_if.master       bus,
  input  wire logic       req,
  input  wire logic       req_read,
  input  wire logic [6:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            busy,
  output logic            done,
  output logic            nack,
  output logic      [7:0] rd_data
);
  // divider needs four clocks per quarter bit and must fit its counter
  if (CLK_DIV < 4 || CLK_DIV > 65536)
  begin : g_div_check
    $error("clock divider out of range");
  end
  logic [15:0] div_cnt;
  logic [1:0]  phase;
  logic        tick;
  logic [5:0]  step;
  logic [3:0]  bitn;
  logic [2:0]  byte_idx;
  logic [7:0]  tx;
  logic        scl_oe_n;
  logic        sda_oe_n;
  logic        rd_op;
  logic [1:0]  sda_meta;
  logic [7:0]  cur_byte;
  logic [2:0]  last_byte;
  logic        reading;
  logic        slot_bit;
  logic        ack_slot;
  logic        frame_end;
  logic        restart;
  logic [5:0]  next_step;
  logic [3:0]  next_bitn;
  logic [2:0]  next_byte_idx;
  logic [7:0]  next_tx;
  // quarter-bit enable from the divider
  assign tick = div_cnt == 16'(CLK_DIV - 1);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      div_cnt <= 16'h0000;
    else
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
  // data line sampled through two flops
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      sda_meta <= 2'b11;
    else
      sda_meta <= {sda_meta[0], bus.sda_in};
  // byte sequence: addr w, index, data | addr w, index, stop-start, addr r, read
  assign last_byte = rd_op ? 3'h3 : 3'h2;
  assign reading   = rd_op && byte_idx == 3'h3;
  always_comb
  begin
    case (byte_idx)
      3'h0: cur_byte = {req_addr, 1'b0};
      3'h1: cur_byte = `LRS_REG_INDEX;
      3'h2: cur_byte = rd_op ? {req_addr, 1'b1} : req_data;
      default: cur_byte = 8'hff;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // slot value, and what follows each ninth clock
  assign slot_bit      = (bitn == 4'h8) ? ~reading : (reading | tx[7]);
  assign ack_slot      = bitn == 4'h8;
  assign frame_end     = ack_slot && (byte_idx == last_byte || nack);
  assign restart       = ack_slot && !frame_end && rd_op && byte_idx == 3'h1;
  assign next_step     = frame_end ? 6'h02 : (restart ? 6'h03 : 6'h01);
  assign next_bitn     = ack_slot ? 4'h0 : bitn + 4'h1;
  assign next_byte_idx = (!ack_slot || frame_end) ? byte_idx : (restart ? 3'h2 : byte_idx + 3'h1);
  assign next_tx       = (ack_slot && !frame_end && !restart)
                         ? ((byte_idx == 3'h0) ? `LRS_REG_INDEX : req_data)
                         : {tx[6:0], 1'b1};
  // bit engine: phase 0 low-set, 1 rise, 2 high, 3 fall
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      busy     <= 1'b0;
      done     <= 1'b0;
      nack     <= 1'b0;
      rd_data  <= 8'h00;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      rd_op    <= 1'b0;
      phase    <= 2'b00;
      bitn     <= 4'h0;
      byte_idx <= 3'h0;
      tx       <= 8'h00;
      step     <= 6'h00;
    end
    else
    begin
      done <= 1'b0;
      if (!busy && req)
      begin
        busy     <= 1'b1;
        nack     <= 1'b0;
        rd_op    <= req_read;
        step     <= 6'h00;
        byte_idx <= 3'h0;
        bitn     <= 4'h0;
        phase    <= 2'b00;
      end
      else if (busy && tick)
      begin
        phase <= phase + 2'b01;
        case (step)
          // start: data low under high clock
          6'h00:
          begin
            if (phase == 2'b01)
              sda_oe_n <= 1'b0;
            if (phase == 2'b11)
            begin
              scl_oe_n <= 1'b0;
              step     <= 6'h01;
              tx       <= cur_byte;
              bitn     <= 4'h0;
            end
          end
          // bit slots, nine per byte
          6'h01:
          begin
            if (phase == 2'b00)
              sda_oe_n <= slot_bit;
            if (phase == 2'b01)
              scl_oe_n <= 1'b1;
            if (phase == 2'b10 && ack_slot && !reading && sda_meta[1])
              nack <= 1'b1;
            if (phase == 2'b10 && !ack_slot && reading)
              rd_data <= {rd_data[6:0], sda_meta[1]};
            if (phase == 2'b11)
            begin
              scl_oe_n <= 1'b0;
              tx       <= next_tx;
              bitn     <= next_bitn;
              byte_idx <= next_byte_idx;
              step     <= next_step;
            end
          end
          // stop, then restart for a read
          6'h02, 6'h03:
          begin
            if (phase == 2'b00)
              sda_oe_n <= 1'b0;
            if (phase == 2'b01)
              scl_oe_n <= 1'b1;
            if (phase == 2'b10)
              sda_oe_n <= 1'b1;
            if (phase == 2'b11 && step == 6'h03)
              step <= 6'h00;
            if (phase == 2'b11 && step == 6'h02)
            begin
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
          default:
            step <= 6'h00;
        endcase
      end
    end
  assign bus.mst_scl_oe_n = scl_oe_n;
  assign bus.mst_sda_oe_n = sda_oe_n;
endmodule
`default_nettype wire

// [lrs_bus_asserts.sv]
// checker watching the two-wire bus between regulator port and master
`timescale 1ns/100ps
`default_nettype none
module lrs_bus_asserts
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       dev_sda_oe_n,
  input wire logic [1:0] addr_strap
);
  logic       scl_d;
  logic       sda_d;
  logic [3:0] bit_n;
  logic [1:0] byte_n;
  logic [7:0] shreg;
  logic       hit;
  logic       rd;
  // line events seen at the system clock
  wire rise  = scl_in & !scl_d;
  wire start = scl_in & scl_d & sda_d & !sda_in;
  wire stop  = scl_in & scl_d & !sda_d & sda_in;
  wire ack9  = rise & (bit_n == 4'h8);
  wire match = shreg[7:1] == {5'h02, addr_strap};
  ////////////////////////////////////////////////////////////////
  // frame tracker: bit and byte counts, address match
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {scl_d, sda_d, hit, rd} <= 4'hc;
      {bit_n, byte_n, shreg}  <= 14'h0000;
    end
    else
    begin
      scl_d <= scl_in;
      sda_d <= sda_in;
      if (start | stop)
      begin
        {bit_n, byte_n, hit} <= 7'h00;
      end
      else if (ack9)
      begin
        bit_n  <= 4'h0;
        byte_n <= byte_n + 2'h1;
        hit    <= (byte_n == 2'h0) ? match : hit;
        rd     <= (byte_n == 2'h0) ? shreg[0] : rd;
      end
      else if (rise)
      begin
        bit_n <= bit_n + 4'h1;
        shreg <= {shreg[6:0], sda_in};
      end
    end
  ////////////////////////////////////////////////////////////////
  // bus rules, sampled at the system clock
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  addr_ack_a: assert property (ack9 && byte_n == 2'h0 && match |-> !dev_sda_oe_n)
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (ack9 && byte_n == 2'h0 && !match |-> dev_sda_oe_n)
    else $error("foreign address acknowledged");
  index_ack_a: assert property (ack9 && byte_n == 2'h1 && hit && !rd && shreg == 8'h00 |-> !dev_sda_oe_n)
    else $error("zero index not acknowledged");
  data_ack_a: assert property (ack9 && byte_n == 2'h2 && hit && !rd |-> !dev_sda_oe_n)
    else $error("control data not acknowledged");
  master_slot_a: assert property (ack9 && byte_n == 2'h1 && hit && rd |-> dev_sda_oe_n)
    else $error("device holds data in master slot");
  miss_silent_a: assert property (byte_n != 2'h0 && !hit |-> dev_sda_oe_n)
    else $error("device drives after mismatch");
  change_low_a: assert property (!$stable(dev_sda_oe_n) |-> !scl_in)
    else $error("device data changed with clock high");
  idle_high_a: assert property (stop |-> scl_in [*4])
    else $error("clock not resting high after stop");
  abandon_a: assert property (start || stop |-> ##[0:4] dev_sda_oe_n)
    else $error("device still driving after start or stop");
  cover property (ack9 && byte_n == 2'h2 && hit && !sda_in);
  cover property (ack9 && byte_n == 2'h1 && hit && rd && !sda_in);
  cover property (ack9 && byte_n == 2'h0 && !match);
endmodule
`default_nettype wire

// [lnb_regulator_i2c_slave_tb.sv]
// self-checking bench joining regulator port and master
`timescale 1ns/100ps
`include "lrs_regs.svh"
`default_nettype none
module lnb_regulator_i2c_slave_tb;
  typedef struct packed {logic nk; logic chk; logic [7:0] rd; logic [7:0] ctrl; logic wr;} lrs_note_t;
  logic       clk;
  logic       rst_n;
  logic [1:0] addr_strap;
  logic [7:0] status_live;
  logic [7:0] fault_set;
  logic       req;
  logic       req_read;
  logic [6:0] req_addr;
  logic [7:0] req_data;
  logic [7:0] ctrl_reg;
  logic       ctrl_wr_pulse;
  logic       wr_seen = 1'b0;
  logic [7:0] fault_latched;
  logic       busy;
  logic       done;
  logic       nack;
  logic [7:0] rd_data;
  logic [7:0] ctrl_exp;
  logic [7:0] d;
  logic [7:0] f;
  lrs_note_t  cur;
  lrs_note_t  notes[$];
  int         fail_count = 0;
  int         compares = 0;
  integer     seed;
  lrs_bus_if bus ();
  lrs_device i_lrs_device
  (
    .clk           (clk),
    .rst_n         (rst_n),
    .bus           (bus),
    .addr_strap    (addr_strap),
    .status_live   (status_live),
    .fault_set     (fault_set),
    .ctrl_reg      (ctrl_reg),
    .ctrl_wr_pulse (ctrl_wr_pulse),
    .fault_latched (fault_latched)
  );
  lrs_master #(.CLK_DIV(4)) i_lrs_master
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .bus      (bus),
    .req      (req),
    .req_read (req_read),
    .req_addr (req_addr),
    .req_data (req_data),
    .busy     (busy),
    .done     (done),
    .nack     (nack),
    .rd_data  (rd_data)
  );
  lrs_bus_asserts i_lrs_bus_asserts
  (
    .clk          (clk),
    .rst_n        (rst_n),
    .scl_in       (bus.scl_in),
    .sda_in       (bus.sda_in),
    .dev_sda_oe_n (bus.dev_sda_oe_n),
    .addr_strap   (addr_strap)
  );
  ////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////
  // compare and closing tasks
  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one transfer: note the outcome, request, wait for done
  task automatic op(input logic r, input logic [6:0] a, input logic [7:0] dv, input logic nk, input logic [7:0] er);
    int n = 0;
    @(posedge clk);
    req      <= 1'b1;
    req_read <= r;
    req_addr <= a;
    req_data <= dv;
    if (!r && !nk)
      ctrl_exp = dv;
    notes.push_back('{nk, r & !nk, er, ctrl_exp, !r & !nk});
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    cmp_bit(busy, 1'b1);
    while (done !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      fail_count++;
      tally_and_finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // result watcher: oldest note against each finished transfer
  always @(posedge clk)
    if (done === 1'b1)
    begin
      cur = notes.pop_front();
      cmp_bit(nack, cur.nk);
      if (cur.chk)
        cmp_byte(rd_data, cur.rd);
      cmp_byte(ctrl_reg, cur.ctrl);
      cmp_bit(wr_seen, cur.wr);
      cmp_bit(busy, 1'b0);
      wr_seen = 1'b0;
    end
    else if (ctrl_wr_pulse === 1'b1)
      wr_seen = 1'b1;
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 32'h0000_eaec;
    {rst_n, req, req_read, req_addr, req_data} = 18'h0_0000;
    {addr_strap, status_live, fault_set, ctrl_exp} = 26'h000_0000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp_byte(ctrl_reg, 8'h00);
    cmp_byte(fault_latched, 8'h00);
    cmp_bit(bus.scl_in & bus.sda_in, 1'b1);
    // every strap: good write, foreign write, status read
    for (int s = 0; s < 4; s++)
    begin
      d = 8'($random(seed));
      @(posedge clk);
      addr_strap  <= s[1:0];
      status_live <= 8'($random(seed));
      repeat (3) @(posedge clk);
      op(1'b0, {`LRS_ADDR_FIXED, s[1:0]}, d, 1'b0, 8'h00);
      op(1'b0, {`LRS_ADDR_FIXED, ~s[1:0]}, ~d, 1'b1, 8'h00);
      op(1'b1, {`LRS_ADDR_FIXED, s[1:0]}, 8'h00, 1'b0, status_live);
    end
    // latched faults survive until the master acknowledges them
    f = 8'($random(seed)) | 8'h01;
    @(posedge clk);
    fault_set <= f;
    @(posedge clk);
    fault_set <= 8'h00;
    @(negedge clk);
    cmp_byte(fault_latched, f);
    op(1'b1, {`LRS_ADDR_FIXED, ~addr_strap}, 8'h00, 1'b1, 8'h00);
    cmp_byte(fault_latched, f);
    op(1'b1, {`LRS_ADDR_FIXED, addr_strap}, 8'h00, 1'b0, status_live | f);
    cmp_byte(fault_latched, 8'h00);
    op(1'b1, {`LRS_ADDR_FIXED, addr_strap}, 8'h00, 1'b0, status_live);
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule
`default_nettype wire
